// file: rtl/ctbc_top.sv
// Charger timer and boost configuration registers behind a two-wire host port.
// Assumes SCL and SDA arrive asynchronously; SDA is open drain, pulled up outside.
module ctbc_top #(
    parameter logic [6:0] DEV_ADDR = ctbc_pkg::DEFAULT_DEV_ADDR,
    parameter int unsigned TICK_CYCLES = ctbc_pkg::CYCLES_PER_SEC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [6:0] thermistor_pct,
    output logic term_enable,
    output logic safety_timer_enable,
    output logic [1:0] fast_charge_limit_sel,
    output logic [4:0] fast_charge_hours,
    output logic watchdog_fault,
    output logic [3:0] boost_output_code,
    output logic [12:0] boost_target_mv,
    output logic [1:0] hot_cutoff_sel,
    output logic [6:0] boost_hot_limit_pct,
    output logic boost_thermal_protect,
    output logic boost_hot_trip,
    output logic thermistor_fault_flag,
    output logic [1:0] thermal_reg_threshold,
    output logic [6:0] thermal_reg_degc
);
    import ctbc_pkg::*;

    ctbc_ctl_if ctl();

    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    ctbc_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] reg_ptr;
    logic rw_bit;
    logic mst_ack;
    logic byte_done;
    logic addr_match;
    logic wr_en;
    logic load_rd;
    logic [7:0] rd_value;
    logic [7:0] timer_ctrl;
    logic [7:0] boost_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only serves edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
    assign byte_done = scl_fall && (bit_cnt == BITS_PER_BYTE);
    assign addr_match = (rx_shift[7:1] == DEV_ADDR);
    assign wr_en = (state == ST_WDATA) && byte_done;
    assign load_rd = scl_fall && (((state == ST_ADDR_ACK) && rw_bit) || ((state == ST_RDATA_ACK) && mst_ack));

    ////////////////////////////////////////////////////////////////////////////
    // Host port sequencing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (start_det) begin
            state <= ST_ADDR;
        end else if (stop_det) begin
            state <= ST_IDLE;
        end else if (scl_fall) begin
            unique case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_ADDR: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        state <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: state <= rw_bit ? ST_RDATA : ST_REG;
                ST_REG: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        state <= ST_REG_ACK;
                    end
                end
                ST_REG_ACK: state <= ST_WDATA;
                ST_WDATA: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        state <= ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: state <= ST_WDATA;
                ST_RDATA: begin
                    if (bit_cnt == BITS_PER_BYTE) begin
                        state <= ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: state <= mst_ack ? ST_RDATA : ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit counting and receive shifting on SCL rising edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 4'h0;
        end else if (start_det) begin
            bit_cnt <= 4'h0;
        end else if (scl_fall && (state == ST_ADDR_ACK || state == ST_REG_ACK ||
                                  state == ST_WDATA_ACK || state == ST_RDATA_ACK)) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state == ST_ADDR || state == ST_REG ||
                                  state == ST_WDATA || state == ST_RDATA)) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_shift <= 8'h00;
        end else if (scl_rise && (state == ST_ADDR || state == ST_REG || state == ST_WDATA)) begin
            rx_shift <= {rx_shift[6:0], sda_s2};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rw_bit <= 1'b0;
        end else if ((state == ST_ADDR) && byte_done) begin
            rw_bit <= rx_shift[0];
        end
    end

    // Host drives SDA low to acknowledge a read byte
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mst_ack <= 1'b0;
        end else if (scl_rise && (state == ST_RDATA_ACK)) begin
            mst_ack <= !sda_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register pointer: set by the offset byte, advanced after each written byte and as each read byte is loaded
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_ptr <= 8'h00;
        end else if ((state == ST_REG) && byte_done) begin
            reg_ptr <= rx_shift;
        end else if (wr_en || load_rd) begin
            reg_ptr <= reg_ptr + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped offsets read as zero
    always_comb begin
        rd_value = UNMAPPED_READ;
        if (reg_ptr == TIMER_CTRL_ADDR) begin
            rd_value = timer_ctrl;
        end else if (reg_ptr == BOOST_CTRL_ADDR) begin
            rd_value = boost_ctrl;
        end else if (reg_ptr == FAULT_ADDR) begin
            rd_value = 8'h00;
            rd_value[FAULT_WD_BIT] = watchdog_fault;
        end
    end

    // Read data goes out MSB first, shifted after each SCL fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_shift <= 8'hff;
        end else if (load_rd) begin
            tx_shift <= rd_value;
        end else if (scl_fall && (state == ST_RDATA) && (bit_cnt != BITS_PER_BYTE)) begin
            tx_shift <= {tx_shift[6:0], 1'b1};
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = (state == ST_ADDR_ACK) || (state == ST_REG_ACK) || (state == ST_WDATA_ACK) ||
                    ((state == ST_RDATA) && !tx_shift[7]);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; reserved bits are kept as written
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_ctrl <= TIMER_CTRL_RESET;
        end else if (wr_en && (reg_ptr == TIMER_CTRL_ADDR)) begin
            timer_ctrl <= rx_shift;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            boost_ctrl <= BOOST_CTRL_RESET;
        end else if (wr_en && (reg_ptr == BOOST_CTRL_ADDR)) begin
            boost_ctrl <= rx_shift;
        end
    end

    assign ctl.timer_ctrl = timer_ctrl;
    assign ctl.boost_ctrl = boost_ctrl;
    // Any accepted data byte counts as host activity
    assign ctl.kick = wr_en;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog fault: expiry wins over the clear-on-read in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            watchdog_fault <= 1'b0;
        end else if (ctl.wd_expired) begin
            watchdog_fault <= 1'b1;
        end else if (load_rd && (reg_ptr == FAULT_ADDR)) begin
            watchdog_fault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Raw field outputs straight from the register flops
    assign term_enable = timer_ctrl[TERM_EN_BIT];
    assign safety_timer_enable = timer_ctrl[TMR_EN_BIT];
    assign fast_charge_limit_sel = timer_ctrl[FC_LSB +: 2];
    assign boost_output_code = boost_ctrl[BV_LSB +: 4];
    assign hot_cutoff_sel = boost_ctrl[HOT_LSB +: 2];
    assign thermal_reg_threshold = boost_ctrl[THERMAL_REG_THRESHOLD_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////
    ctbc_watchdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wdog (
        .sys_clk(sys_clk),
        .rst(rst),
        .ctl(ctl.wdog)
    );

    ctbc_decode u_dec (
        .sys_clk(sys_clk),
        .rst(rst),
        .ctl(ctl.dec),
        .thermistor_pct(thermistor_pct),
        .fast_charge_hours(fast_charge_hours),
        .boost_target_mv(boost_target_mv),
        .boost_hot_limit_pct(boost_hot_limit_pct),
        .boost_thermal_protect(boost_thermal_protect),
        .boost_hot_trip(boost_hot_trip),
        .thermistor_fault_flag(thermistor_fault_flag),
        .thermal_reg_degc(thermal_reg_degc)
    );

endmodule

// file: common/ctbc_pkg.sv
// Shared constants and types for the charger timer and boost configuration block.
// Assumes a 10 MHz system clock and a serial host port run as a byte-wide register slave.
package ctbc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEC_NS = 1_000_000_000;
    localparam int unsigned CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets and reset values
    localparam logic [7:0] TIMER_CTRL_ADDR = 8'h05;
    localparam logic [7:0] BOOST_CTRL_ADDR = 8'h06;
    localparam logic [7:0] FAULT_ADDR = 8'h09;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h9a;
    localparam logic [7:0] BOOST_CTRL_RESET = 8'h73;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Arbitrary default, not tied to any product
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int TERM_EN_BIT = 7;
    localparam int WD_LSB = 4;
    localparam int TMR_EN_BIT = 3;
    localparam int FC_LSB = 1;
    localparam int BV_LSB = 4;
    localparam int HOT_LSB = 2;
    localparam int THERMAL_REG_THRESHOLD_LSB = 0;
    localparam int FAULT_WD_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Field encodings
    localparam logic [1:0] WD_OFF = 2'b00;
    localparam logic [1:0] WD_40 = 2'b01;
    localparam logic [1:0] WD_80 = 2'b10;
    localparam logic [7:0] WD_SEC_40 = 8'd40;
    localparam logic [7:0] WD_SEC_80 = 8'd80;
    localparam logic [7:0] WD_SEC_160 = 8'd160;
    localparam logic [4:0] FC_HRS_5 = 5'd5;
    localparam logic [4:0] FC_HRS_8 = 5'd8;
    localparam logic [4:0] FC_HRS_12 = 5'd12;
    localparam logic [4:0] FC_HRS_20 = 5'd20;
    localparam logic [12:0] BOOST_BASE_MV = 13'd4550;
    localparam logic [12:0] BOOST_STEP_MV = 13'd64;
    localparam logic [1:0] HOT_OFF = 2'b11;
    localparam logic [6:0] HOT_PCT_33 = 7'd33;
    localparam logic [6:0] HOT_PCT_36 = 7'd36;
    localparam logic [6:0] HOT_PCT_30 = 7'd30;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_DEG_60 = 7'd60;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_DEG_80 = 7'd80;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_DEG_100 = 7'd100;
    localparam logic [6:0] THERMAL_REG_THRESHOLD_DEG_120 = 7'd120;
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;

    ////////////////////////////////////////////////////////////////////////////
    // Host port states, Gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0011,
        ST_REG       = 4'b0010,
        ST_REG_ACK   = 4'b0110,
        ST_WDATA     = 4'b0111,
        ST_WDATA_ACK = 4'b0101,
        ST_RDATA     = 4'b0100,
        ST_RDATA_ACK = 4'b1100
    } ctbc_state_t;

endpackage

// file: common/ctbc_ctl_if.sv
// Carries the two control registers and watchdog handshakes between the block's modules.
// Assumes all parties run on sys_clk.
interface ctbc_ctl_if;
    logic [7:0] timer_ctrl;
    logic [7:0] boost_ctrl;
    logic kick;
    logic wd_expired;
    modport owner(output timer_ctrl, output boost_ctrl, output kick, input wd_expired);
    modport wdog(input timer_ctrl, input kick, output wd_expired);
    modport dec(input timer_ctrl, input boost_ctrl);
endinterface

// file: rtl/ctbc_watchdog.sv
// Host watchdog: counts seconds since the last host write and flags expiry once.
// Assumes the kick is a one-cycle pulse on sys_clk.
module ctbc_watchdog #(
    parameter int unsigned TICK_CYCLES = ctbc_pkg::CYCLES_PER_SEC
) (
    input wire logic sys_clk,
    input wire logic rst,
    ctbc_ctl_if.wdog ctl
);
    import ctbc_pkg::*;

    logic [31:0] tick_cnt;
    logic [7:0] sec_cnt;
    logic [7:0] limit;
    logic done;
    logic tick_end;

    always_comb begin
        unique case (ctl.timer_ctrl[WD_LSB +: 2])
            WD_OFF: limit = 8'h00;
            WD_40: limit = WD_SEC_40;
            WD_80: limit = WD_SEC_80;
            default: limit = WD_SEC_160;
        endcase
    end

    assign tick_end = (tick_cnt == 32'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // One-second prescaler, restarted by each host write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 32'h0;
        end else if (ctl.kick || limit == 8'h00 || done || tick_end) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sec_cnt <= 8'h00;
        end else if (ctl.kick || limit == 8'h00) begin
            sec_cnt <= 8'h00;
        end else if (tick_end && !done) begin
            sec_cnt <= sec_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expiry fires once and then waits for the next host write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            ctl.wd_expired <= 1'b0;
        end else begin
            ctl.wd_expired <= 1'b0;
            if (ctl.kick) begin
                done <= 1'b0;
            end else if (!done && limit != 8'h00 && sec_cnt >= limit) begin
                done <= 1'b1;
                ctl.wd_expired <= 1'b1;
            end
        end
    end

endmodule

// file: rtl/ctbc_decode.sv
// Turns the two control registers into settings for the charge and boost loops.
// Assumes thermistor_pct is a same-clock reading in percent of the internal rail.
module ctbc_decode (
    input wire logic sys_clk,
    input wire logic rst,
    ctbc_ctl_if.dec ctl,
    input wire logic [6:0] thermistor_pct,
    output logic [4:0] fast_charge_hours,
    output logic [12:0] boost_target_mv,
    output logic [6:0] boost_hot_limit_pct,
    output logic boost_thermal_protect,
    output logic boost_hot_trip,
    output logic thermistor_fault_flag,
    output logic [6:0] thermal_reg_degc
);
    import ctbc_pkg::*;

    logic [4:0] hrs;
    logic [6:0] hot_pct;
    logic [6:0] deg;
    logic [1:0] hot_sel;

    assign hot_sel = ctl.boost_ctrl[HOT_LSB +: 2];

    always_comb begin
        unique case (ctl.timer_ctrl[FC_LSB +: 2])
            2'b00: hrs = FC_HRS_5;
            2'b01: hrs = FC_HRS_8;
            2'b10: hrs = FC_HRS_12;
            default: hrs = FC_HRS_20;
        endcase
        // Second and third codes swapped versus the printed order, to be confirmed
        unique case (hot_sel)
            2'b01: hot_pct = HOT_PCT_36;
            2'b10: hot_pct = HOT_PCT_30;
            default: hot_pct = HOT_PCT_33;
        endcase
        unique case (ctl.boost_ctrl[THERMAL_REG_THRESHOLD_LSB +: 2])
            2'b00: deg = THERMAL_REG_THRESHOLD_DEG_60;
            2'b01: deg = THERMAL_REG_THRESHOLD_DEG_80;
            2'b10: deg = THERMAL_REG_THRESHOLD_DEG_100;
            default: deg = THERMAL_REG_THRESHOLD_DEG_120;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered so downstream loops never see a half-written setting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fast_charge_hours <= 5'h00;
            boost_target_mv <= 13'h0000;
            boost_hot_limit_pct <= 7'h00;
            boost_thermal_protect <= 1'b0;
            boost_hot_trip <= 1'b0;
            thermistor_fault_flag <= 1'b0;
            thermal_reg_degc <= 7'h00;
        end else begin
            fast_charge_hours <= ctl.timer_ctrl[TMR_EN_BIT] ? hrs : 5'h00;
            boost_target_mv <= BOOST_BASE_MV + BOOST_STEP_MV * {9'h000, ctl.boost_ctrl[BV_LSB +: 4]};
            boost_hot_limit_pct <= hot_pct;
            boost_thermal_protect <= (hot_sel != HOT_OFF);
            boost_hot_trip <= (hot_sel != HOT_OFF) && (thermistor_pct < hot_pct);
            thermistor_fault_flag <= (thermistor_pct < hot_pct);
            thermal_reg_degc <= deg;
        end
    end

endmodule

// file: testbench/ctbc_properties.sv
// Concurrent checks on the decoded outputs of the configuration block.
// Assumes one sys_clk domain; bound to ctbc_top after the module.
module ctbc_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [6:0] thermistor_pct,
    input wire logic term_enable,
    input wire logic safety_timer_enable,
    input wire logic [1:0] fast_charge_limit_sel,
    input wire logic [4:0] fast_charge_hours,
    input wire logic watchdog_fault,
    input wire logic [3:0] boost_output_code,
    input wire logic [12:0] boost_target_mv,
    input wire logic [1:0] hot_cutoff_sel,
    input wire logic [6:0] boost_hot_limit_pct,
    input wire logic boost_thermal_protect,
    input wire logic boost_hot_trip,
    input wire logic thermistor_fault_flag,
    input wire logic [1:0] thermal_reg_threshold,
    input wire logic [6:0] thermal_reg_degc
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    chk_reset_values: assert property (
        $fell(rst) |-> {term_enable, safety_timer_enable, fast_charge_limit_sel} == 4'hd && !watchdog_fault
        && {boost_output_code, hot_cutoff_sel, thermal_reg_threshold} == 8'h73) else $error("bad reset values");
    chk_hours_off: assert property (
        !safety_timer_enable |=> fast_charge_hours == 5'd0) else $error("hours not zero");
    chk_hours_five: assert property (
        safety_timer_enable && fast_charge_limit_sel == 2'b00 |=> fast_charge_hours == 5'd5) else $error("not 5 h");
    chk_hours_twenty: assert property (
        safety_timer_enable && fast_charge_limit_sel == 2'b11 |=> fast_charge_hours == 5'd20) else $error("not 20 h");
    chk_boost_step: assert property (
        1'b1 |=> boost_target_mv == 13'd4550 + 13'd64 * {9'h0, $past(boost_output_code)}) else $error("boost mv");
    chk_hot_code_one: assert property (
        hot_cutoff_sel == 2'b01 |=> boost_hot_limit_pct == 7'd36 && boost_thermal_protect) else $error("hot 01");
    chk_hot_code_two: assert property (
        hot_cutoff_sel == 2'b10 |=> boost_hot_limit_pct == 7'd30 && boost_thermal_protect) else $error("hot 10");
    chk_hot_disabled: assert property (
        hot_cutoff_sel == 2'b11 |=> boost_hot_limit_pct == 7'd33 && !boost_thermal_protect && !boost_hot_trip)
        else $error("hot off");
    chk_therm_flag: assert property (
        1'b1 |=> thermistor_fault_flag == ($past(thermistor_pct) < boost_hot_limit_pct)) else $error("ntc flag");
    chk_trip_needs_protect: assert property (
        boost_hot_trip == (boost_thermal_protect && thermistor_fault_flag)) else $error("hot trip");
    chk_thermal_reg_threshold_span: assert property (
        thermal_reg_threshold == 2'b00 |=> thermal_reg_degc == 7'd60 ##1 1'b1) else $error("thermal_reg_threshold 60");
    chk_thermal_reg_threshold_top: assert property (
        thermal_reg_threshold == 2'b11 |=> thermal_reg_degc == 7'd120) else $error("thermal_reg_threshold 120");
endmodule
// Every checker port has the same name as a top port
bind ctbc_top ctbc_properties u_chk (.*);

// file: testbench/ctbc_host_model.sv
// Two-wire host model: bit-bangs SCL and pulls SDA low, never drives it high.
// Assumes the bench resolves SDA with a pull-up from all pull-downs.
module ctbc_host_model (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Six cycles a phase, clear of the four-cycle floor
    task automatic half();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low = !b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
        half();
    endtask
    // Last high releases SDA for the ninth bit: ACK in, or NACK out
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(last, a);
        ack = !a;
    endtask
endmodule

// file: testbench/test_charger_timer_boost_config.sv
// Self-checking bench for the configuration block, driven through the host model.
// Assumes a shortened second so watchdog periods fit the run.
module test_charger_timer_boost_config;
    import ctbc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T = 100;
    localparam logic [6:0] DEV = DEFAULT_DEV_ADDR;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] thermistor_pct = 7'd50;
    logic scl, host_low, sda_out, sda_oe, term_enable, safety_timer_enable, watchdog_fault;
    logic boost_thermal_protect, boost_hot_trip, thermistor_fault_flag;
    logic [1:0] fast_charge_limit_sel, hot_cutoff_sel, thermal_reg_threshold;
    logic [4:0] fast_charge_hours;
    logic [3:0] boost_output_code;
    logic [12:0] boost_target_mv;
    logic [6:0] boost_hot_limit_pct, thermal_reg_degc;
    logic [7:0] d, v;
    int err_count = 0;
    int comparisons = 0;
    wire logic sda;
    assign sda = !(host_low || sda_oe);
    always #50 sys_clk = ~sys_clk;
    ctbc_top #(.TICK_CYCLES(T)) dut (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .thermistor_pct(thermistor_pct), .term_enable(term_enable),
        .safety_timer_enable(safety_timer_enable), .fast_charge_limit_sel(fast_charge_limit_sel),
        .fast_charge_hours(fast_charge_hours), .watchdog_fault(watchdog_fault), .boost_output_code(boost_output_code),
        .boost_target_mv(boost_target_mv), .hot_cutoff_sel(hot_cutoff_sel), .boost_hot_limit_pct(boost_hot_limit_pct),
        .boost_thermal_protect(boost_thermal_protect), .boost_hot_trip(boost_hot_trip),
        .thermistor_fault_flag(thermistor_fault_flag), .thermal_reg_threshold(thermal_reg_threshold),
        .thermal_reg_degc(thermal_reg_degc));
    ctbc_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(host_low));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] dat);
        logic [7:0] q;
        logic a0, a1, a2;
        host.start();
        host.xbyte({DEV, 1'b0}, 1'b1, q, a0);
        host.xbyte(off, 1'b1, q, a1);
        host.xbyte(dat, 1'b1, q, a2);
        host.stop();
        check("write ack", {a0, a1, a2}, 3'b111);
    endtask
    // Offset write, repeated start, one byte, NACK
    task automatic rd(input logic [7:0] off, output logic [7:0] dat);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        host.start();
        host.xbyte({DEV, 1'b0}, 1'b1, q, a0);
        host.xbyte(off, 1'b1, q, a1);
        host.start();
        host.xbyte({DEV, 1'b1}, 1'b1, q, a2);
        host.xbyte(8'hff, 1'b1, dat, a3);
        host.stop();
        check("read ack", {a0, a1, a2}, 3'b111);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #9_000_000;
        err_count++;
        summarize();
    end
    initial begin
        int hrs[4] = '{5, 8, 12, 20};
        int lim[4] = '{33, 36, 30, 33};
        int deg[4] = '{60, 80, 100, 120};
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check("hours", fast_charge_hours, 5'd8);
        check("sda out", sda_out, 1'b0);
        check("boost mv", boost_target_mv, 13'd4998);
        check("thermal_reg_threshold", thermal_reg_degc, 7'd120);
        rd(FAULT_ADDR, d);
        check("fault reg", d, 8'h00);
        rd(8'h05, d);
        check("timer reg", d, 8'h9a);
        rd(8'h06, d);
        check("boost reg", d, 8'h73);
        rd(8'h07, d);
        check("unmapped", d, 8'h00);
        host.start();
        host.xbyte({DEV ^ 7'h01, 1'b0}, 1'b1, d, v[0]);
        host.stop();
        check("foreign ack", v[0], 1'b0);
        thermistor_pct = 7'd32;
        for (int i = 0; i < 4; i++) begin
            v = {i[0], 3'b001, 1'b1, i[1:0], 1'b0};
            wr(8'h05, v);
            check("term", term_enable, i[0]);
            check("hours", fast_charge_hours, hrs[i]);
            rd(8'h05, d);
            check("timer back", d, v);
            v = {4'(i * 5), i[1:0], i[1:0]};
            wr(8'h06, v);
            check("boost mv", boost_target_mv, 13'(4550 + 320 * i));
            check("hot limit", boost_hot_limit_pct, lim[i]);
            check("protect", boost_thermal_protect, i != 3);
            check("ntc flag", thermistor_fault_flag, 32 < lim[i]);
            check("trip", boost_hot_trip, i != 3 && 32 < lim[i]);
            check("thermal_reg_threshold", thermal_reg_degc, deg[i]);
            rd(8'h06, d);
            check("boost back", d, v);
        end
        wr(8'h05, 8'h90);
        check("hours off", fast_charge_hours, 5'd0);
        for (int i = 1; i < 4; i++) begin
            wr(8'h05, {2'b10, i[1:0], 4'b1000});
            repeat ((20 << i) * T - 100) @(posedge sys_clk);
            #1;
            check("early fault", watchdog_fault, 1'b0);
            repeat (200) @(posedge sys_clk);
            #1;
            check("fault", watchdog_fault, 1'b1);
            rd(FAULT_ADDR, d);
            check("fault reg", d, 8'h80);
            check("fault cleared", watchdog_fault, 1'b0);
        end
        wr(8'h05, 8'h88);
        repeat (170 * T) @(posedge sys_clk);
        #1;
        check("wd off", watchdog_fault, 1'b0);
        summarize();
    end
endmodule
